// ==== rtl/rcs_params.svh ====
// Offsets, field positions and reset values of the channel status and configuration bank
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH
`define RCS_OFS_MODE     8'h42
`define RCS_OFS_DEEMPH   8'h43
`define RCS_OFS_IDLE     8'h44
`define RCS_OFS_ID       8'h51
`define RCS_RST_MODE     8'hAD
`define RCS_RST_DEEMPH   5'h02
`define RCS_RST_IDLE     8'h00
`define RCS_RST_RATE     2'h0
`define RCS_BIT_MODE     6
`define RCS_DEM_HI       2
`define RCS_IDA_HI       3
`define RCS_IDA_LO       2
`define RCS_IDD_HI       1
`define RCS_SMB_ADDR     7'h18
`define RCS_PIN_RST      6'h03
`define RCS_BYTE_BITS    4'h8
`define RCS_LAST_BIT     4'h7
`endif

// ==== rtl/rcs_pkg.sv ====
// Types shared by the channel status and configuration bank
package rcs_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_AACK = 8'h04,
    ST_CMD  = 8'h08,
    ST_WDAT = 8'h10,
    ST_WACK = 8'h20,
    ST_TX   = 8'h40,
    ST_MACK = 8'h80
  } rcs_smb_state_t;

  typedef struct packed {
    logic [2:0] deemph;
    logic [1:0] idle_assert;
    logic [1:0] idle_deassert;
    logic       gen12_mode;
  } rcs_cfg_t;

  typedef struct packed {
    logic       rx_found;
    logic [1:0] rate;
  } rcs_stat_t;
endpackage

// ==== rtl/rcs_pin_sync.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module rcs_pin_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Bit takes the agreed value, else keeps its old one
  always_comb begin
    q_nxt = (s2_r & s3_r) | (q_r & (s2_r | s3_r));
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      q_r  <= RST;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule

// ==== rtl/rcs_regs.sv ====
// Channel status and configuration registers behind an SMBus slave port
//
// Summary of operation
// - Bit 7 of register 0x43 reads 1 once a far receiver is detected.
// - Bits 6:5 report detected rate: 00 gen1, 01 gen2, 11 gen3.
// - Detected rate field updates only while the rate strap selects automatic.
// - Writable de-emphasis code in bits 2:0, resets to 010.
// - Idle assert threshold in 0x44 bits 3:2 overrides strap, resets 00.
// - Idle de-assert threshold in 0x44 bits 1:0 overrides strap, resets 00.
// - Link training exchanges pass through untouched; no participation.
// - Mode bit 6 of 0x42: 1 selects gen1/2, 0 gen3; overrides strap.
`timescale 1ns/10ps
`include "rcs_params.svh"
module rcs_regs #(
  parameter logic [6:0] SMB_ADDR   = `RCS_SMB_ADDR,
  parameter logic [2:0] ID_VERSION = 3'h1,
  parameter logic [4:0] ID_PART    = 5'h0A
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        rx_found_i,
  input  wire logic [1:0]  rate_det_i,
  input  wire logic        rate_auto_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output rcs_pkg::rcs_cfg_t  cfg_o,
  output rcs_pkg::rcs_stat_t stat_o
);
  // Identification values above are arbitrary
  logic [5:0]               pins_s;
  logic                     scl_s, sda_s, rxf_s, auto_s;
  logic [1:0]               rate_s;
  rcs_pkg::rcs_smb_state_t  st_r, st_nxt;
  logic [3:0]               cnt_r, cnt_nxt;
  logic [7:0]               sh_r, sh_nxt;
  logic [7:0]               ptr_r, ptr_nxt;
  logic                     rw_r, rw_nxt;
  logic                     oe_r, oe_nxt;
  logic                     nack_r, nack_nxt;
  logic                     scl_q_r, sda_q_r, sda_lo_r;
  logic                     wr_en, scl_rise, scl_fall, start, stop;
  logic [7:0]               r42_r, r42_nxt;
  logic [4:0]               r43_r, r43_nxt;
  logic [7:0]               r44_r, r44_nxt;
  logic [1:0]               rate_r, rate_nxt;
  logic                     rxf_r, rxf_nxt;

  rcs_pin_sync #(
    .W   (6),
    .RST (`RCS_PIN_RST)
  ) u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    ({rate_auto_i, rx_found_i, rate_det_i, sda_i, scl_i}),
    .q_o    (pins_s)
  );

  assign scl_s  = pins_s[0];
  assign sda_s  = pins_s[1];
  assign rate_s = pins_s[3:2];
  assign rxf_s  = pins_s[4];
  assign auto_s = pins_s[5];

  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign start    = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop     = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // Unmapped offsets read as zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      `RCS_OFS_MODE:   rd_byte = r42_r;
      `RCS_OFS_DEEMPH: rd_byte = {rxf_r, rate_r, r43_r};
      `RCS_OFS_IDLE:   rd_byte = r44_r;
      `RCS_OFS_ID:     rd_byte = {ID_VERSION, ID_PART};
      default:         rd_byte = 8'h00;
    endcase
  endfunction

  // SMBus byte engine; pointer auto-increments so block reads and writes walk the map
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    ptr_nxt  = ptr_r;
    rw_nxt   = rw_r;
    oe_nxt   = oe_r;
    nack_nxt = nack_r;
    wr_en    = 1'b0;
    if (start) begin
      st_nxt  = rcs_pkg::ST_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end else if (stop) begin
      st_nxt = rcs_pkg::ST_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        rcs_pkg::ST_ADDR, rcs_pkg::ST_CMD, rcs_pkg::ST_WDAT: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == `RCS_BYTE_BITS) begin
            cnt_nxt = 4'h0;
            if (st_r == rcs_pkg::ST_ADDR) begin
              if (sh_r[7:1] == SMB_ADDR) begin
                rw_nxt = sh_r[0];
                oe_nxt = 1'b1;
                st_nxt = rcs_pkg::ST_AACK;
              end else begin
                st_nxt = rcs_pkg::ST_IDLE;
              end
            end else begin
              oe_nxt = 1'b1;
              st_nxt = rcs_pkg::ST_WACK;
              if (st_r == rcs_pkg::ST_CMD) begin
                ptr_nxt = sh_r;
              end else begin
                wr_en   = 1'b1;
                ptr_nxt = ptr_r + 8'h01;
              end
            end
          end
        end
        rcs_pkg::ST_AACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              sh_nxt  = rd_byte(ptr_r);
              ptr_nxt = ptr_r + 8'h01;
              oe_nxt  = ~sh_nxt[7];
              st_nxt  = rcs_pkg::ST_TX;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = rcs_pkg::ST_CMD;
            end
          end
        end
        rcs_pkg::ST_WACK: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
            st_nxt = rcs_pkg::ST_WDAT;
          end
        end
        rcs_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == `RCS_LAST_BIT) begin
              cnt_nxt = 4'h0;
              oe_nxt  = 1'b0;
              st_nxt  = rcs_pkg::ST_MACK;
            end else begin
              sh_nxt  = {sh_r[6:0], 1'b0};
              oe_nxt  = ~sh_nxt[7];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        rcs_pkg::ST_MACK: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
          end else if (scl_fall) begin
            if (nack_r) begin
              st_nxt = rcs_pkg::ST_IDLE;
            end else begin
              sh_nxt  = rd_byte(ptr_r);
              ptr_nxt = ptr_r + 8'h01;
              oe_nxt  = ~sh_nxt[7];
              st_nxt  = rcs_pkg::ST_TX;
            end
          end
        end
        rcs_pkg::ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        default: begin
          st_nxt = rcs_pkg::ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r     <= rcs_pkg::ST_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      ptr_r    <= 8'h00;
      rw_r     <= 1'b0;
      oe_r     <= 1'b0;
      nack_r   <= 1'b0;
      scl_q_r  <= 1'b1;
      sda_q_r  <= 1'b1;
      sda_lo_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      sh_r     <= sh_nxt;
      ptr_r    <= ptr_nxt;
      rw_r     <= rw_nxt;
      oe_r     <= oe_nxt;
      nack_r   <= nack_nxt;
      scl_q_r  <= scl_s;
      sda_q_r  <= sda_s;
      sda_lo_r <= 1'b0;
    end
  end

  // Register bank; reserved bits are stored so they read back as written
  always_comb begin
    r42_nxt  = r42_r;
    r43_nxt  = r43_r;
    r44_nxt  = r44_r;
    rxf_nxt  = rxf_s;
    rate_nxt = rate_r;
    // Outside automatic mode the detector output is meaningless, so the field freezes
    if (auto_s) begin
      rate_nxt = rate_s;
    end
    if (wr_en) begin
      case (ptr_r)
        `RCS_OFS_MODE:   r42_nxt = sh_r;
        `RCS_OFS_DEEMPH: r43_nxt = sh_r[4:0];
        `RCS_OFS_IDLE:   r44_nxt = sh_r;
        default:         r42_nxt = r42_r;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r42_r  <= `RCS_RST_MODE;
      r43_r  <= `RCS_RST_DEEMPH;
      r44_r  <= `RCS_RST_IDLE;
      rate_r <= `RCS_RST_RATE;
      rxf_r  <= 1'b0;
    end else begin
      r42_r  <= r42_nxt;
      r43_r  <= r43_nxt;
      r44_r  <= r44_nxt;
      rate_r <= rate_nxt;
      rxf_r  <= rxf_nxt;
    end
  end

  // Only settings, status and the SMBus data drive leave the block; the serial data path is never intercepted
  assign cfg_o.deemph        = r43_r[`RCS_DEM_HI:0];
  assign cfg_o.idle_assert   = r44_r[`RCS_IDA_HI:`RCS_IDA_LO];
  assign cfg_o.idle_deassert = r44_r[`RCS_IDD_HI:0];
  assign cfg_o.gen12_mode    = r42_r[`RCS_BIT_MODE];
  assign stat_o.rx_found     = rxf_r;
  assign stat_o.rate         = rate_r;
  assign sda_oe_o            = oe_r;
  assign sda_o               = sda_lo_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic wr43;
  logic wr44;
  logic wr42;
  assign wr43 = wr_en && ptr_r == `RCS_OFS_DEEMPH;
  assign wr44 = wr_en && ptr_r == `RCS_OFS_IDLE;
  assign wr42 = wr_en && ptr_r == `RCS_OFS_MODE;

  a_rx_flag_set: assert property (rx_found_i [*6] |-> stat_o.rx_found)
    else $error("receiver flag not set");
  a_rx_flag_clear: assert property (!rx_found_i [*6] |-> !stat_o.rx_found)
    else $error("receiver flag not cleared");
  a_rate_track: assert property ((rate_auto_i && $stable(rate_det_i)) [*6]
    |-> stat_o.rate == rate_det_i)
    else $error("rate field does not track detector");
  a_rate_frozen: assert property (!auto_s |=> $stable(stat_o.rate))
    else $error("rate field moved outside automatic mode");
  a_deemph_write: assert property (wr43 |=> cfg_o.deemph == $past(sh_r[2:0]))
    else $error("de-emphasis write lost");
  a_deemph_hold: assert property (!wr43 |=> $stable(cfg_o.deemph))
    else $error("de-emphasis changed without write");
  a_idle_assert: assert property (wr44 |=> cfg_o.idle_assert == $past(sh_r[3:2]))
    else $error("idle assert threshold write lost");
  a_idle_deassert: assert property (wr44 |=> cfg_o.idle_deassert == $past(sh_r[1:0]))
    else $error("idle de-assert threshold write lost");
  a_mode_bit: assert property (wr42 |=> cfg_o.gen12_mode == $past(sh_r[6]))
    else $error("mode bit write lost");
  a_id_read: assert property (st_r == rcs_pkg::ST_AACK && scl_fall && rw_r
    && ptr_r == `RCS_OFS_ID |=> sh_r == {ID_VERSION, ID_PART})
    else $error("identification byte wrong");

  c_deemph_write: cover property (wr43);
  c_id_read: cover property (st_r == rcs_pkg::ST_TX && ptr_r == 8'h52);
  c_master_nack: cover property (st_r == rcs_pkg::ST_MACK && nack_r && scl_fall);
  c_rate_change: cover property (auto_s && $changed(stat_o.rate));
endmodule

// ==== test/rcs_smb_host.sv ====
// SMBus host master model for the register port of the bank
`timescale 1ns/10ps
module rcs_smb_host #(
  parameter int HB = 16
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o     = 1'h1;
    sda_low_o = 1'h0;
  end

  task automatic hb();
    repeat (HB) @(posedge clk_i);
  endtask

  // Also serves as repeated start: SDA is released before SCL rises
  task automatic start();
    sda_low_o <= 1'h0;
    hb();
    scl_o <= 1'h1;
    hb();
    sda_low_o <= 1'h1;
    hb();
    scl_o <= 1'h0;
  endtask

  task automatic stop();
    hb();
    sda_low_o <= 1'h1;
    hb();
    scl_o <= 1'h1;
    hb();
    sda_low_o <= 1'h0;
    hb();
  endtask

  // SDA moves only mid-way through SCL low, so no change looks like start or stop
  task automatic bit_io(input logic b, output logic s);
    hb();
    sda_low_o <= !b;
    hb();
    scl_o <= 1'h1;
    hb();
    s = sda_i;
    scl_o <= 1'h0;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'h1, s);
    ack = !s;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, s);
      d[i] = s;
    end
    // Last byte gets a released SDA (no acknowledge) so the slave stops driving
    bit_io(last, s);
  endtask
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the channel status and configuration bank
`timescale 1ns/10ps
`include "rcs_params.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module tb_top;
  localparam logic [7:0] ID_EXP = 8'h53;
  logic               clk_i       = 1'h0;
  logic               srst_i      = 1'h1;
  logic               rx_found_i  = 1'h0;
  logic [1:0]         rate_det_i  = 2'h0;
  logic               rate_auto_i = 1'h0;
  logic               scl;
  logic               sda_low;
  logic               sda_o;
  logic               sda_oe_o;
  rcs_pkg::rcs_cfg_t  cfg_o;
  rcs_pkg::rcs_stat_t stat_o;
  int                 err_count   = 0;
  int                 checks_done = 0;
  logic [2:0]         acks;
  logic [7:0]         rd_v;
  // Open-drain line with pull-up
  wire logic          sda = !(sda_low || (sda_oe_o && !sda_o));

  always #2.5 clk_i = !clk_i;

  rcs_smb_host host (
    .clk_i     (clk_i),
    .sda_i     (sda),
    .scl_o     (scl),
    .sda_low_o (sda_low)
  );

  // Identification value is arbitrary
  rcs_regs #(
    .ID_VERSION (3'h2),
    .ID_PART    (5'h13)
  ) DUT (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .scl_i       (scl),
    .sda_i       (sda),
    .rx_found_i  (rx_found_i),
    .rate_det_i  (rate_det_i),
    .rate_auto_i (rate_auto_i),
    .sda_o       (sda_o),
    .sda_oe_o    (sda_oe_o),
    .cfg_o       (cfg_o),
    .stat_o      (stat_o)
  );

  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d);
    host.start();
    host.put_byte({dev, 1'h0}, acks[2]);
    host.put_byte(ofs, acks[1]);
    host.put_byte(d, acks[0]);
    host.stop();
  endtask

  task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp);
    host.start();
    host.put_byte({`RCS_SMB_ADDR, 1'h0}, acks[2]);
    host.put_byte(ofs, acks[1]);
    host.start();
    host.put_byte({`RCS_SMB_ADDR, 1'h1}, acks[0]);
    host.get_byte(1'h1, rd_v);
    host.stop();
    `CHK(acks, 3'h7)
    `CHK(rd_v, exp)
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk_i);
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    `CHK(cfg_o, ({3'h2, 2'h0, 2'h0, 1'h0}))
    rchk(`RCS_OFS_DEEMPH, 8'h02);
    rchk(`RCS_OFS_IDLE, 8'h00);
    rchk(`RCS_OFS_ID, ID_EXP);
    wr(`RCS_SMB_ADDR, `RCS_OFS_ID, 8'hFF);
    `CHK(acks, 3'h7)
    rchk(`RCS_OFS_ID, ID_EXP);
    rchk(8'h60, 8'h00);
    wr(`RCS_SMB_ADDR, `RCS_OFS_MODE, 8'hED);
    `CHK(cfg_o.gen12_mode, 1'h1)
    wr(`RCS_SMB_ADDR, `RCS_OFS_MODE, 8'hAD);
    `CHK(cfg_o.gen12_mode, 1'h0)
    rchk(`RCS_OFS_MODE, 8'hAD);
    // Status bits are written as ones to prove they ignore writes
    for (int i = 0; i < 8; i++) begin
      wr(`RCS_SMB_ADDR, `RCS_OFS_DEEMPH, {3'h7, 2'h0, 3'(i)});
      `CHK(cfg_o.deemph, 3'(i))
      rchk(`RCS_OFS_DEEMPH, {3'h0, 2'h0, 3'(i)});
    end
    for (int i = 0; i < 4; i++) begin
      wr(`RCS_SMB_ADDR, `RCS_OFS_IDLE, {4'h0, 2'(i), 2'(3 - i)});
      `CHK(cfg_o.idle_assert, 2'(i))
      `CHK(cfg_o.idle_deassert, 2'(3 - i))
    end
    rchk(`RCS_OFS_IDLE, 8'h0C);
    rx_found_i  <= 1'h1;
    rate_auto_i <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      if (i != 2) begin
        rate_det_i <= 2'(i);
        repeat (8) @(posedge clk_i);
        `CHK(stat_o, ({1'h1, 2'(i)}))
        rchk(`RCS_OFS_DEEMPH, {1'h1, 2'(i), 5'h07});
      end
    end
    rate_auto_i <= 1'h0;
    repeat (8) @(posedge clk_i);
    rate_det_i <= 2'h1;
    repeat (8) @(posedge clk_i);
    `CHK(stat_o.rate, 2'h3)
    rchk(`RCS_OFS_DEEMPH, 8'hE7);
    rate_auto_i <= 1'h1;
    rx_found_i  <= 1'h0;
    repeat (8) @(posedge clk_i);
    `CHK(stat_o, ({1'h0, 2'h1}))
    // A foreign address must be ignored entirely
    wr(7'h22, `RCS_OFS_DEEMPH, 8'h00);
    `CHK(acks, 3'h0)
    `CHK(cfg_o.deemph, 3'h7)
    report_and_stop();
  end
endmodule
